// ===== common/i2c_ctl_consts.svh
// Constants of the two-wire bus controller: field positions, reset values, timing counts.
// Assumes inclusion by bare name from any design or bench file.
`ifndef I2C_CTL_CONSTS_SVH
`define I2C_CTL_CONSTS_SVH

// Byte sent when a slave read finds no data and stretching is off.
`define FILL_BYTE       8'hff
// Reset value of the transfer control register.
`define TCR_RESET       17'h00000
// Least kernel cycles between a control write and a slave-hit clear.
`define KERNEL_SETUP_CYCLES 3
// Kernel clock period in nanoseconds.
`define KERNEL_PERIOD_NS    100
// Last bit index inside a byte, and last clock of a nine-clock slot.
`define BYTE_LAST       4'h7
`define SLOT_LAST       4'h8
// Position of the direction bit in the address byte.
`define ADDR_RW_POS     0

`endif

// ===== common/i2c_ctl_pkg.sv
// Types shared by the two-wire bus controller and its bench.
// Assumes nothing of its surroundings; holds types only.
`default_nettype none

package i2c_ctl_pkg;

  // Transfer control register image.
  typedef struct packed {
    logic [6:0] target_addr;
    logic [7:0] nbytes;
    logic       rd_wrn;
    logic       start_req;
  } tcr_t;

  // Flag clear register image, one write-one-to-clear bit each.
  typedef struct packed {
    logic underrun_clear;
    logic line_error_clear;
    logic slave_hit_clear_bit;
  } fcr_t;

  // Event status register image.
  typedef struct packed {
    logic slave_dir;
    logic master_busy;
    logic bus_busy;
    logic transmit_ready_flag;
    logic underrun_flag;
    logic line_error_flag;
    logic slave_hit;
  } esr_t;

  // Slave byte engine states, Gray coded along the read path but for the S_HOLD to S_TX step.
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_AACK = 3'h3,
    S_TX   = 3'h2,
    S_TACK = 3'h6,
    S_HOLD = 3'h7
  } slv_state_t;

endpackage

`default_nettype wire

// ===== hw/i2c_master_slave_controller.sv
// Control core of a two-wire bus controller acting as master requester and read slave at once.
// Assumes pins sampled on CLK_SYS (the kernel clock) and an outside engine that runs
// the master transfer once MST_LAUNCH fires.
`timescale 1ns/100ps
`default_nettype none

`include "i2c_ctl_consts.svh"

module i2c_master_slave_controller #(
  parameter int TX_DEPTH = 2
) (
  input  wire logic                    CLK_SYS,
  input  wire logic                    NRST,
  input  wire logic                    BLOCK_ON,
  input  wire logic                    HOLD_OFF_DISABLE,
  input  wire logic                    BYTE_BY_BYTE_SLAVE,
  input  wire logic [6:0]              OWN_ADDR,
  input  wire logic                    TCR_WR,
  input  wire i2c_ctl_pkg::tcr_t       TCR_WDATA,
  output i2c_ctl_pkg::tcr_t            TCR,
  input  wire logic                    FCR_WR,
  input  wire i2c_ctl_pkg::fcr_t       FCR_WDATA,
  input  wire logic                    TX_VALID,
  input  wire logic [7:0]              TX_DATA,
  output logic                         TX_READY,
  output i2c_ctl_pkg::esr_t            STATUS,
  output logic                         MST_LAUNCH,
  output i2c_ctl_pkg::tcr_t            MST_CFG,
  input  wire logic                    SCL_I,
  output logic                         SCL_O,
  output logic                         SCL_OE,
  input  wire logic                    SDA_I,
  output logic                         SDA_O,
  output logic                         SDA_OE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  i2c_ctl_pkg::slv_state_t state;      // Slave byte engine state.
  i2c_ctl_pkg::tcr_t       tcr;        // Transfer control register.
  logic       scl_q;                   // Line levels one cycle ago.
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [3:0] slot_cnt;                // Clock count inside the current nine-clock slot.
  logic [3:0] bitcnt;                  // Bit count inside the slave byte.
  logic [7:0] shreg;                   // Slave shift register.
  logic       ack_drive;               // Slave pulls SDA low for its acknowledge.
  logic       got_ack;                 // Master acknowledged the last byte.
  logic       slave_dir;               // Direction bit of the last address byte, 1 for read.
  logic       slave_hit;               // Own address matched, not yet cleared.
  logic       line_error;
  logic       underrun;
  logic       bus_busy;
  logic       master_busy;             // Our launched transfer owns the bus.
  logic       hit_set;
  logic       byte_edge;               // Moment a new slave byte must begin.
  logic       stretch_need;
  logic       load_fire;
  logic       hold_enter;
  logic       launch;
  logic       flush;
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       buf_pop;
  logic [7:0] addr_byte;

  // ----------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------
  assign scl_rise   = SCL_I & ~scl_q;
  assign scl_fall   = ~SCL_I & scl_q;
  assign start_cond = scl_q & SCL_I & sda_q & ~SDA_I;
  assign stop_cond  = scl_q & SCL_I & ~sda_q & SDA_I;
  assign addr_byte  = {shreg[6:0], SDA_I};
  assign flush      = ~BLOCK_ON;

  // Previous line levels for edge and condition detection.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
    end
  end

  // Slot counter; a start or stop anywhere but slot boundary is misplaced.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      slot_cnt <= 4'h0;
    end
    else if (flush || start_cond || stop_cond)
    begin
      slot_cnt <= 4'h0;
    end
    else if (scl_rise)
    begin
      slot_cnt <= (slot_cnt == `SLOT_LAST) ? 4'h0 : slot_cnt + 4'h1;
    end
  end

  // Bus occupancy follows start and stop conditions.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      bus_busy <= 1'b0;
    end
    else if (flush || stop_cond)
    begin
      bus_busy <= 1'b0;
    end
    else if (start_cond)
    begin
      bus_busy <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer; ready means room, so an empty buffer asks twice
  // ----------------------------------------------------------------
  tx_skid_buffer #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_txbuf (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .flush     (flush),
    .in_valid  (TX_VALID),
    .in_data   (TX_DATA),
    .in_ready  (TX_READY),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // ----------------------------------------------------------------
  // Slave byte engine
  // ----------------------------------------------------------------
  // A new read byte starts after the address acknowledge, after a
  // master acknowledge, or while stretched.
  assign byte_edge    = (state == i2c_ctl_pkg::S_AACK && scl_fall && ack_drive && slave_dir) ||
                        (state == i2c_ctl_pkg::S_TACK && scl_fall && got_ack) ||
                        (state == i2c_ctl_pkg::S_HOLD);
  // Stretch while the hit is unserved or no byte is ready; never when stretching is off.
  assign stretch_need = ~HOLD_OFF_DISABLE & (slave_hit | ~buf_valid);
  assign load_fire    = byte_edge & ~stretch_need;
  assign hold_enter   = byte_edge & stretch_need;
  assign buf_pop      = load_fire & buf_valid;
  assign hit_set      = (state == i2c_ctl_pkg::S_ADDR) && scl_rise && (bitcnt == `BYTE_LAST) &&
                        (addr_byte[7:1] == OWN_ADDR);

  // The engine restarts on every start and drops out on stop or block off.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state     <= i2c_ctl_pkg::S_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      ack_drive <= 1'b0;
      got_ack   <= 1'b0;
      slave_dir <= 1'b0;
    end
    else if (flush || stop_cond)
    begin
      state     <= i2c_ctl_pkg::S_IDLE;
      ack_drive <= 1'b0;
      got_ack   <= 1'b0;
    end
    else if (start_cond)
    begin
      state     <= i2c_ctl_pkg::S_ADDR;
      bitcnt    <= 4'h0;
      ack_drive <= 1'b0;
      got_ack   <= 1'b0;
    end
    else if (load_fire)
    begin
      // An empty buffer without stretching sends the fill byte.
      state     <= i2c_ctl_pkg::S_TX;
      shreg     <= buf_valid ? buf_data : `FILL_BYTE;
      bitcnt    <= 4'h0;
      ack_drive <= 1'b0;
      got_ack   <= 1'b0;
    end
    else if (hold_enter)
    begin
      state     <= i2c_ctl_pkg::S_HOLD;
      ack_drive <= 1'b0;
      got_ack   <= 1'b0;
    end
    else
    begin
      case (state)
        i2c_ctl_pkg::S_ADDR:
        begin
          // Address byte shifts in MSB first; only our address is answered.
          if (scl_rise)
          begin
            shreg  <= addr_byte;
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == `BYTE_LAST)
            begin
              state     <= hit_set ? i2c_ctl_pkg::S_AACK : i2c_ctl_pkg::S_IDLE;
              slave_dir <= addr_byte[`ADDR_RW_POS];
            end
          end
        end
        i2c_ctl_pkg::S_AACK:
        begin
          // First fall drives the acknowledge, second releases it.
          if (scl_fall)
          begin
            if (!ack_drive)
            begin
              ack_drive <= 1'b1;
            end
            else
            begin
              ack_drive <= 1'b0;
              state     <= i2c_ctl_pkg::S_IDLE;
            end
          end
        end
        i2c_ctl_pkg::S_TX:
        begin
          if (scl_rise)
          begin
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (bitcnt == `SLOT_LAST)
            begin
              state <= i2c_ctl_pkg::S_TACK;
            end
            else
            begin
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        i2c_ctl_pkg::S_TACK:
        begin
          // A not-acknowledge ends the read.
          if (scl_rise)
          begin
            if (SDA_I)
            begin
              state <= i2c_ctl_pkg::S_IDLE;
            end
            else
            begin
              got_ack <= 1'b1;
            end
          end
        end
        i2c_ctl_pkg::S_IDLE,
        i2c_ctl_pkg::S_HOLD:
        begin
          state <= state;
        end
        default:
        begin
          state <= i2c_ctl_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      slave_hit <= 1'b0;
    end
    else if (flush)
    begin
      slave_hit <= 1'b0;
    end
    else if (hit_set)
    begin
      slave_hit <= 1'b1;
    end
    else if (FCR_WR && FCR_WDATA.slave_hit_clear_bit)
    begin
      slave_hit <= 1'b0;
    end
  end

  // Misplaced start or stop while our transfer runs; the transfer is left alone.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      line_error <= 1'b0;
    end
    else if (master_busy && (start_cond || stop_cond) && slot_cnt > 4'h1)
    begin
      line_error <= 1'b1;
    end
    else if (FCR_WR && FCR_WDATA.line_error_clear)
    begin
      line_error <= 1'b0;
    end
  end

  // Every fill byte raises the underrun flag, however late the write came.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      underrun <= 1'b0;
    end
    else if (load_fire && !buf_valid)
    begin
      underrun <= 1'b1;
    end
    else if (FCR_WR && FCR_WDATA.underrun_clear)
    begin
      underrun <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer control and master launch
  // ----------------------------------------------------------------
  // Launch needs a free bus; a request made while busy simply waits, so
  // the launch uses whatever the register holds when the bus frees.
  assign launch = tcr.start_req & ~bus_busy & ~master_busy & BLOCK_ON;

  // The start request is dropped by a slave-hit clear, not by the match itself.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      tcr <= `TCR_RESET;
    end
    else if (flush)
    begin
      tcr.start_req <= 1'b0;
    end
    else if (TCR_WR)
    begin
      tcr           <= TCR_WDATA;
      tcr.start_req <= TCR_WDATA.start_req & ~(FCR_WR & FCR_WDATA.slave_hit_clear_bit);
    end
    else if ((FCR_WR && FCR_WDATA.slave_hit_clear_bit) || launch)
    begin
      tcr.start_req <= 1'b0;
    end
  end

  // Launch pulse and the configuration captured with it.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      MST_LAUNCH  <= 1'b0;
      MST_CFG     <= `TCR_RESET;
      master_busy <= 1'b0;
    end
    else
    begin
      MST_LAUNCH <= launch;
      if (launch)
      begin
        MST_CFG     <= tcr;
        master_busy <= 1'b1;
      end
      else if (flush || stop_cond)
      begin
        master_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign TCR    = tcr;
  assign SCL_O  = 1'b0;
  assign SDA_O  = 1'b0;
  // Clock held low only while stretched; data pulled low for zeros and acknowledge.
  assign SCL_OE = (state == i2c_ctl_pkg::S_HOLD);
  assign SDA_OE = ack_drive | ((state == i2c_ctl_pkg::S_TX) & ~shreg[7]);
  assign STATUS = '{slave_dir:           slave_dir & BYTE_BY_BYTE_SLAVE | slave_dir,
                    master_busy:         master_busy,
                    bus_busy:            bus_busy,
                    transmit_ready_flag: TX_READY,
                    underrun_flag:       underrun,
                    line_error_flag:     line_error,
                    slave_hit:           slave_hit};

endmodule

`default_nettype wire

// ===== hw/tx_skid_buffer.sv
// Small valid/ready buffer in front of the transmit shifter.
// Assumes one clock, asynchronous active-low reset, DEPTH a power of two.
`timescale 1ns/100ps
`default_nettype none

module tx_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];   // Entry storage, flip-flops.
  logic [AW-1:0]    wr_ptr;        // Next entry to fill.
  logic [AW-1:0]    rd_ptr;        // Oldest entry.
  logic [AW:0]      count;         // Entries held.
  logic             push;
  logic             pop;

  // Full and empty come straight from the count, so a stalled drain backs up the writer.
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  // ----------------------------------------------------------------
  // Storage write.
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and occupancy; a flush empties the buffer at once.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ===== tb/i2c_bus_partner.sv
// Behavioural second master on the shared two-wire bus.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/100ps
`default_nettype none

module i2c_bus_partner (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // Both lines start released; the clock stands still between frames.
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // A third of a bus bit, five kernel cycles, ending just after an edge.
  task automatic half();
    repeat (5) @(posedge clk);
    #1;
  endtask

  // A slave may stretch; the wait is bounded so a stuck clock cannot hang.
  task automatic wait_hi();
    int n;
    n = 0;
    while (scl !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask

  // One clock: data set while low, sampled well inside the high phase.
  task automatic bit_c(input logic b, output logic r);
    sda_low = ~b;
    half();
    scl_low = 1'b0;
    wait_hi();
    half();
    r = sda;
    half();
    scl_low = 1'b1;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start_c();
    sda_low = 1'b0;
    half();
    scl_low = 1'b0;
    wait_hi();
    half();
    sda_low = 1'b1;
    half();
    scl_low = 1'b1;
  endtask

  // Stop: data rises while the clock is high, then the bus is left idle.
  task automatic stop_c();
    sda_low = 1'b1;
    half();
    scl_low = 1'b0;
    wait_hi();
    half();
    sda_low = 1'b0;
  endtask

  // Byte out, most significant bit first, then the receiver's answer.
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_c(b[i], r);
    bit_c(1'b1, ack);
  endtask

  // Byte in from the slave, then acknowledge or refuse it.
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, d[i]);
    bit_c(nack, r);
  endtask
endmodule

`default_nettype wire

// ===== tb/i2c_ctl_properties.sv
// Concurrent checks on the ports of the two-wire bus controller.
// Assumes binding to the top module; one clock domain, async active-low reset.
`timescale 1ns/100ps
`default_nettype none

module i2c_ctl_properties (
  input wire logic              CLK_SYS,
  input wire logic              NRST,
  input wire logic              BLOCK_ON,
  input wire logic              HOLD_OFF_DISABLE,
  input wire logic              TCR_WR,
  input wire logic              FCR_WR,
  input wire i2c_ctl_pkg::fcr_t FCR_WDATA,
  input wire i2c_ctl_pkg::tcr_t TCR,
  input wire i2c_ctl_pkg::esr_t STATUS,
  input wire logic              MST_LAUNCH,
  input wire i2c_ctl_pkg::tcr_t MST_CFG,
  input wire logic              SCL_OE,
  input wire logic              SDA_OE
);
  // ----------------------------------------------------------------
  // Launch of a master transfer.
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  // A launch is a single pulse, caused by a waiting request on a free bus.
  a_launch_pulse: assert property (MST_LAUNCH |=> !MST_LAUNCH)
    else $error("launch pulse lasted more than one cycle.");
  a_launch_cause: assert property (MST_LAUNCH |-> $past(TCR.start_req) && !$past(STATUS.bus_busy)
    && !TCR.start_req && STATUS.master_busy) else $error("launch without a pending request.");
  // The engine gets the set-up held at the moment of launch.
  a_launch_cfg: assert property (MST_LAUNCH |-> MST_CFG[16:1] == $past(TCR[16:1]))
    else $error("launched set-up differs from the control register.");

  // ----------------------------------------------------------------
  // Slave hit and start request.
  // ----------------------------------------------------------------
  // The address match alone must leave a waiting request alone.
  a_match_keeps: assert property ($rose(STATUS.slave_hit) && $past(TCR.start_req) && !$past(TCR_WR)
    && !$past(FCR_WR) && $past(BLOCK_ON) |-> TCR.start_req) else $error("match dropped the request.");
  a_hitclr_drops: assert property (FCR_WR && FCR_WDATA.slave_hit_clear_bit |=> !TCR.start_req)
    else $error("hit clear left the start request set.");
  // A stretch begun while the hit is pending holds until the hit goes.
  a_hit_hold: assert property (SCL_OE && STATUS.slave_hit && BLOCK_ON |=>
    SCL_OE || !STATUS.slave_hit || !BLOCK_ON) else $error("stretch released while the hit is pending.");
  a_no_stretch: assert property (HOLD_OFF_DISABLE && $past(HOLD_OFF_DISABLE) |-> !SCL_OE)
    else $error("clock held low with stretching off.");

  // ----------------------------------------------------------------
  // Flags and disable.
  // ----------------------------------------------------------------
  a_lerr_sticky: assert property (STATUS.line_error_flag && !(FCR_WR && FCR_WDATA.line_error_clear)
    |=> STATUS.line_error_flag) else $error("line error dropped without a clear.");
  a_block_idle: assert property (!BLOCK_ON |=> !SCL_OE && !SDA_OE && !STATUS.slave_hit
    && !STATUS.master_busy && !STATUS.bus_busy && !TCR.start_req) else $error("block off left activity.");
endmodule

bind i2c_master_slave_controller i2c_ctl_properties u_props (
  .CLK_SYS          (CLK_SYS),
  .NRST             (NRST),
  .BLOCK_ON         (BLOCK_ON),
  .HOLD_OFF_DISABLE (HOLD_OFF_DISABLE),
  .TCR_WR           (TCR_WR),
  .FCR_WR           (FCR_WR),
  .FCR_WDATA        (FCR_WDATA),
  .TCR              (TCR),
  .STATUS           (STATUS),
  .MST_LAUNCH       (MST_LAUNCH),
  .MST_CFG          (MST_CFG),
  .SCL_OE           (SCL_OE),
  .SDA_OE           (SDA_OE)
);

`default_nettype wire

// ===== tb/i2c_master_slave_controller_tb_top.sv
// Self-checking bench for the two-wire bus controller.
// Assumes the partner model as the other master; pins resolved here with pull-ups.
`timescale 1ns/100ps
`default_nettype none

module i2c_master_slave_controller_tb_top;
  logic              clk, nrst, block_on, hold_off, bbs, tcr_wr, fcr_wr, tx_valid, tx_ready;
  logic              mst_launch, scl_o, scl_oe, sda_o, sda_oe, p_scl_low, p_sda_low, ack;
  logic [6:0]        own_addr;
  logic [7:0]        tx_data, d;
  i2c_ctl_pkg::tcr_t tcr_wdata, tcr, mst_cfg, last_cfg;
  i2c_ctl_pkg::fcr_t fcr_wdata;
  i2c_ctl_pkg::esr_t status;
  wire logic         scl, sda;
  int                num_errors, cmp_count, launches, cyc;

  // Open-drain lines: any party pulling low wins, otherwise the pull-up.
  assign scl = (scl_oe ? scl_o : 1'b1) & ~p_scl_low;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~p_sda_low;

  i2c_master_slave_controller DUT (
    .CLK_SYS(clk), .NRST(nrst), .BLOCK_ON(block_on), .HOLD_OFF_DISABLE(hold_off),
    .BYTE_BY_BYTE_SLAVE(bbs), .OWN_ADDR(own_addr), .TCR_WR(tcr_wr), .TCR_WDATA(tcr_wdata),
    .TCR(tcr), .FCR_WR(fcr_wr), .FCR_WDATA(fcr_wdata), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .STATUS(status), .MST_LAUNCH(mst_launch), .MST_CFG(mst_cfg),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe)
  );
  i2c_bus_partner pm (.clk(clk), .scl(scl), .sda(sda), .scl_low(p_scl_low), .sda_low(p_sda_low));

  // ----------------------------------------------------------------
  // Clock, launch monitor and hang guard.
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Sampled on the falling edge so the one-cycle pulse is settled.
  always @(negedge clk)
    if (mst_launch === 1'b1)
    begin
      launches++;
      last_cfg = mst_cfg;
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks.
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobes drop for a cycle between back-to-back calls.
  task automatic wr_tcr(input i2c_ctl_pkg::tcr_t v);
    tcr_wdata = v;
    tcr_wr = 1'b1;
    step(1);
    tcr_wr = 1'b0;
    step(1);
  endtask
  task automatic wr_fcr(input i2c_ctl_pkg::fcr_t v);
    fcr_wdata = v;
    fcr_wr = 1'b1;
    step(1);
    fcr_wr = 1'b0;
    step(1);
  endtask
  task automatic wr_tx(input logic [7:0] v);
    int n;
    tx_data = v;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 50)
    begin
      step(1);
      n++;
    end
    num_errors += (n == 50);
    step(1);
    tx_valid = 1'b0;
    step(1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    block_on = 1'b1;
    hold_off = 1'b0;
    bbs = 1'b0;
    own_addr = 7'h2a;
    tcr_wr = 1'b0;
    tcr_wdata = '0;
    fcr_wr = 1'b0;
    fcr_wdata = '0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    step(4);
    nrst = 1'b1;
    chk("tcr", tcr, 17'h0);
    chk("status", 17'(status), 17'h8);
    // Free bus: the request launches at once with the written set-up.
    wr_tcr(17'h04409);
    step(3);
    chk("launches", 17'(launches), 17'h1);
    chk("cfg", {last_cfg[16:1], 1'b0}, 17'h04408);
    chk("start", 17'(tcr.start_req), 17'h0);
    // A restart in mid-slot while mastering raises the sticky line error.
    pm.start_c();
    repeat (3) pm.bit_c(1'b1, ack);
    pm.start_c();
    step(2);
    chk("lerr", 17'(status.line_error_flag), 17'h1);
    chk("mbusy", 17'(status.master_busy), 17'h1);
    pm.stop_c();
    step(5);
    chk("lerr", 17'(status.line_error_flag), 17'h1);
    wr_fcr(3'h2);
    chk("lerr", 17'(status.line_error_flag), 17'h0);
    // Addressed while a request waits on a busy bus, no byte preloaded.
    pm.start_c();
    wr_tcr(17'h04409);
    pm.send(8'h55, ack);
    chk("ack", 17'(ack), 17'h0);
    fork
      pm.recv(1'b0, d);
      begin
        step(20);
        chk("stretch", 17'(scl_oe), 17'h1);
        chk("start", 17'(tcr.start_req), 17'h1);
        chk("st", 17'(status), 17'h59);
        wr_tx(8'ha5);
        wr_tx(8'h3c);
        chk("txrdy", 17'(tx_ready), 17'h0);
        wr_fcr(3'h1);
        chk("start", 17'(tcr.start_req), 17'h0);
        chk("stretch", 17'(scl_oe), 17'h0);
        wr_tcr(17'h04408);
      end
    join
    chk("data", 17'(d), 17'ha5);
    pm.recv(1'b1, d);
    chk("data", 17'(d), 17'h3c);
    pm.stop_c();
    step(20);
    chk("launches", 17'(launches), 17'h1);
    // Stretching off and nothing queued: fill byte and underrun.
    hold_off = 1'b1;
    bbs = 1'b1;
    pm.start_c();
    pm.send(8'h55, ack);
    wr_tcr(17'h04408);
    step(4);
    wr_fcr(3'h1);
    wr_tcr(17'h04408);
    pm.recv(1'b1, d);
    chk("data", 17'(d), 17'hff);
    chk("under", 17'(status.underrun_flag), 17'h1);
    pm.stop_c();
    wr_fcr(3'h4);
    chk("under", 17'(status.underrun_flag), 17'h0);
    // Switching the block off frees a stretched clock at once.
    hold_off = 1'b0;
    bbs = 1'b0;
    wr_tx(8'h5a);
    pm.start_c();
    pm.send(8'h55, ack);
    fork
      pm.recv(1'b1, d);
      begin
        step(20);
        chk("stretch", 17'(scl_oe), 17'h1);
        block_on = 1'b0;
        step(2);
        chk("stretch", 17'(scl_oe), 17'h0);
        chk("hit", 17'(status.slave_hit), 17'h0);
        block_on = 1'b1;
      end
    join
    pm.stop_c();
    wrap_up();
  end
endmodule

`default_nettype wire
